//--- rtl/optical_sample_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module optical_sample_fifo (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic link_cmd_valid_i,
  input wire logic [1:0] link_cmd_op_i,
  input wire logic [7:0] link_cmd_byte_i,
  output logic link_cmd_ready_o,
  output logic link_rsp_valid_o,
  output logic [7:0] link_rsp_byte_o,
  input wire logic sample_valid_i,
  input wire logic [17:0] sample_red_i,
  input wire logic [17:0] sample_ir_i,
  input wire logic [1:0] adc_resolution_i,
  input wire logic single_channel_mode_i,
  output logic almost_full_o
);
  typedef struct packed {
    logic [1:0] req_pipe;
    logic ack_tgl;
    logic [7:0] rdata;
    logic [7:0] reg_addr;
    logic [osf_pkg::DEPTH-1:0][osf_pkg::ENTRY_W-1:0] mem;
    logic [osf_pkg::IDX_W-1:0] write_index;
    logic [osf_pkg::IDX_W-1:0] read_index;
    logic full;
    logic [osf_pkg::IDX_W-1:0] lost_sample_count;
    logic [7:0] cfg;
    logic almost_full;
    logic [2:0] byte_idx;
    logic [osf_pkg::ENTRY_W-1:0] held;
    logic [5:0] avg_cnt;
    logic [osf_pkg::ACC_W-1:0] acc_red;
    logic [osf_pkg::ACC_W-1:0] acc_ir;
  } core_state_t;

  osf_link_if xf();

  core_state_t s;
  core_state_t next;
  logic new_req;
  logic rd_req;
  logic port_rd;
  logic empty;
  logic first_rd;
  logic group_done;
  logic stored;
  logic dropped;
  logic [2:0] last_byte;
  logic [2:0] averaging_select;
  logic wrap_on_full_enable;
  logic [3:0] full_threshold;
  logic [osf_pkg::CH_W-1:0] red_j;
  logic [osf_pkg::CH_W-1:0] ir_j;
  logic [osf_pkg::ACC_W-1:0] sum_red;
  logic [osf_pkg::ACC_W-1:0] sum_ir;
  logic [osf_pkg::IDX_W-1:0] free_after;

  function automatic logic [7:0] bump_addr(input logic [7:0] a);
    if (a == osf_pkg::SAMPLE_PORT_ADDR || a == osf_pkg::TOP_ADDR) begin
      return a;
    end
    return a + 8'h01;
  endfunction : bump_addr

  function automatic logic [7:0] sample_byte(input logic [osf_pkg::ENTRY_W-1:0] e,
                                             input logic [2:0] idx);
    logic [osf_pkg::CH_W-1:0] ch;
    logic [1:0] k;
    ch = (idx < 3'h3) ? e[osf_pkg::ENTRY_W-1:osf_pkg::CH_W] : e[osf_pkg::CH_W-1:0];
    k = (idx < 3'h3) ? idx[1:0] : 2'(idx - 3'h3);
    case (k)
      2'h0: return {6'h00, ch[17:16]};
      2'h1: return ch[15:8];
      default: return ch[7:0];
    endcase
  endfunction : sample_byte

  // raw results arrive right-justified at 15..18 bits; the top bit ends up at 17
  function automatic logic [osf_pkg::CH_W-1:0] left_justify(input logic [17:0] raw,
                                                           input logic [1:0] res);
    return raw << (2'h3 - res);
  endfunction : left_justify

  function automatic logic [2:0] avg_shift(input logic [2:0] code);
    return (code > 3'h4) ? 3'h5 : code;
  endfunction : avg_shift

  function automatic logic [5:0] avg_last(input logic [2:0] code);
    return 6'((7'h01 << avg_shift(code)) - 7'h01);
  endfunction : avg_last

  assign averaging_select = s.cfg[osf_pkg::AVG_LSB+2:osf_pkg::AVG_LSB];
  assign wrap_on_full_enable = s.cfg[osf_pkg::WRAP_BIT];
  assign full_threshold = s.cfg[osf_pkg::THR_LSB+3:osf_pkg::THR_LSB];
  assign new_req = s.req_pipe[1] != s.ack_tgl;
  assign rd_req = new_req && (xf.op == osf_pkg::LINK_READ);
  assign port_rd = rd_req && (s.reg_addr == osf_pkg::SAMPLE_PORT_ADDR);
  assign empty = !s.full && (s.write_index == s.read_index);
  assign first_rd = port_rd && (s.byte_idx == 3'h0) && !empty;
  assign last_byte = single_channel_mode_i ? osf_pkg::LAST_BYTE_ONE_CH
                                           : osf_pkg::LAST_BYTE_TWO_CH;
  // a shortened group after a code change still closes instead of hanging
  assign group_done = sample_valid_i && (s.avg_cnt >= avg_last(averaging_select));
  assign red_j = left_justify(sample_red_i, adc_resolution_i);
  assign ir_j = left_justify(sample_ir_i, adc_resolution_i);
  assign sum_red = s.acc_red + {5'h00, red_j};
  assign sum_ir = s.acc_ir + {5'h00, ir_j};

  always_comb begin
    next = s;
    next.req_pipe = {s.req_pipe[0], xf.req_tgl};
    stored = 1'b0;
    dropped = 1'b0;
    free_after = '0;
    if (new_req) begin
      next.ack_tgl = s.req_pipe[1];
      case (xf.op)
        osf_pkg::LINK_SET_ADDR: begin
          next.reg_addr = xf.wdata;
          next.byte_idx = 3'h0;
        end
        osf_pkg::LINK_WRITE: begin
          case (s.reg_addr)
            osf_pkg::WRITE_INDEX_ADDR: begin
              next.write_index = xf.wdata[osf_pkg::IDX_W-1:0];
              next.full = 1'b0;
            end
            osf_pkg::LOST_COUNT_ADDR: begin
              next.lost_sample_count = xf.wdata[osf_pkg::IDX_W-1:0];
            end
            osf_pkg::READ_INDEX_ADDR: begin
              next.read_index = xf.wdata[osf_pkg::IDX_W-1:0];
              next.full = 1'b0;
              next.byte_idx = 3'h0;
            end
            osf_pkg::BUFFER_CFG_ADDR: begin
              next.cfg = xf.wdata;
            end
            default: begin
            end
          endcase
          next.reg_addr = bump_addr(s.reg_addr);
        end
        default: begin
          case (s.reg_addr)
            osf_pkg::STATUS1_ADDR: begin
              next.rdata = 8'h00;
              next.rdata[osf_pkg::ALMOST_FULL_BIT] = s.almost_full;
              next.almost_full = 1'b0;
            end
            osf_pkg::WRITE_INDEX_ADDR: next.rdata = {3'h0, s.write_index};
            osf_pkg::LOST_COUNT_ADDR: next.rdata = {3'h0, s.lost_sample_count};
            osf_pkg::READ_INDEX_ADDR: next.rdata = {3'h0, s.read_index};
            osf_pkg::SAMPLE_PORT_ADDR: begin
              if (s.byte_idx == 3'h0) begin
                if (empty) begin
                  // nothing unread: answer zero and leave the read index alone
                  next.rdata = 8'h00;
                end else begin
                  next.held = s.mem[s.read_index];
                  next.rdata = sample_byte(s.mem[s.read_index], 3'h0);
                  next.read_index = s.read_index + 5'h01;
                  next.full = 1'b0;
                  next.lost_sample_count = 5'h00;
                  next.byte_idx = 3'h1;
                end
              end else begin
                next.rdata = sample_byte(s.held, s.byte_idx);
                next.byte_idx = (s.byte_idx >= last_byte) ? 3'h0 : s.byte_idx + 3'h1;
              end
            end
            osf_pkg::BUFFER_CFG_ADDR: next.rdata = s.cfg;
            default: next.rdata = 8'h00;
          endcase
          next.reg_addr = bump_addr(s.reg_addr);
        end
      endcase
    end
    if (sample_valid_i) begin
      if (group_done) begin
        next.avg_cnt = 6'h00;
        next.acc_red = '0;
        next.acc_ir = '0;
        if (next.full && !next.cfg[osf_pkg::WRAP_BIT]) begin
          dropped = 1'b1;
          if (next.lost_sample_count != osf_pkg::LOST_MAX) begin
            next.lost_sample_count = next.lost_sample_count + 5'h01;
          end
        end else begin
          stored = 1'b1;
          next.mem[next.write_index] = {osf_pkg::CH_W'(sum_red >> avg_shift(averaging_select)),
                                        osf_pkg::CH_W'(sum_ir >> avg_shift(averaging_select))};
          // rollover drags the read index along so the unread count stays at 32
          if (next.full) begin
            next.read_index = next.read_index + 5'h01;
          end
          next.write_index = next.write_index + 5'h01;
          next.full = next.full || (next.write_index == next.read_index);
          free_after = next.full ? 5'h00 : next.read_index - next.write_index;
          if (free_after == {1'b0, next.cfg[osf_pkg::THR_LSB+3:osf_pkg::THR_LSB]}) begin
            next.almost_full = 1'b1;
          end
        end
      end else begin
        next.avg_cnt = s.avg_cnt + 6'h01;
        next.acc_red = sum_red;
        next.acc_ir = sum_ir;
      end
    end
    if (!nrst_i) begin
      next = '0;
      next.cfg = osf_pkg::CFG_RESET;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s <= next;
  end

  assign xf.ack_tgl = s.ack_tgl;
  assign xf.rdata = s.rdata;
  assign almost_full_o = s.almost_full;

  osf_link_port link_port (
    .link_clk_i(link_clk_i),
    .nrst_i(nrst_i),
    .cmd_valid_i(link_cmd_valid_i),
    .cmd_op_i(link_cmd_op_i),
    .cmd_byte_i(link_cmd_byte_i),
    .cmd_ready_o(link_cmd_ready_o),
    .rsp_valid_o(link_rsp_valid_o),
    .rsp_byte_o(link_rsp_byte_o),
    .xf(xf)
  );

  default clocking core_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence first_byte_s;
    first_rd && !stored;
  endsequence

  sequence drop_s;
    group_done && s.full && !wrap_on_full_enable && !new_req;
  endsequence

  sequence status_read_s;
    rd_req && (s.reg_addr == osf_pkg::STATUS1_ADDR);
  endsequence

  depth_wrap_a: assert property (
    (stored && !new_req && s.write_index == 5'h1F) |=> (s.write_index == 5'h00))
    else $error("write index did not wrap from 31 to 0");

  sample_len_a: assert property (
    (port_rd && s.byte_idx != 3'h0 && s.byte_idx == last_byte) |=> (s.byte_idx == 3'h0))
    else $error("sample length in bytes is wrong");

  port_addr_hold_a: assert property (
    port_rd |=> (s.reg_addr == osf_pkg::SAMPLE_PORT_ADDR) [*2])
    else $error("data port read moved the register address");

  addr_advance_a: assert property (
    (new_req && xf.op != osf_pkg::LINK_SET_ADDR && s.reg_addr != osf_pkg::SAMPLE_PORT_ADDR
     && s.reg_addr != osf_pkg::TOP_ADDR) |=> (s.reg_addr == $past(s.reg_addr) + 8'h01))
    else $error("register address did not advance");

  top_addr_hold_a: assert property (
    (rd_req && s.reg_addr == osf_pkg::TOP_ADDR) |=> (s.reg_addr == osf_pkg::TOP_ADDR))
    else $error("address wrapped past the top register");

  pad_bits_a: assert property (
    first_rd |=> (s.rdata[7:2] == 6'h00 && s.byte_idx == 3'h1))
    else $error("unused triplet bits are not zero");

  read_advance_a: assert property (
    first_byte_s |=> (s.read_index == $past(s.read_index) + 5'h01)
                     && (s.lost_sample_count == 5'h00))
    else $error("read index or lost count wrong after first byte");

  write_advance_a: assert property (
    (stored && !new_req && !s.full) |=> (s.write_index == $past(s.write_index) + 5'h01))
    else $error("write index did not step on a stored sample");

  reset_clear_a: assert property (@(posedge sys_clk_i) disable iff (1'b0)
    !nrst_i |=> (s.write_index == 5'h00 && s.read_index == 5'h00 && !s.full))
    else $error("reset did not clear the indices");

  avg_bypass_a: assert property (
    (sample_valid_i && averaging_select == 3'h0 && !s.full && !new_req)
      |=> (s.write_index == $past(s.write_index) + 5'h01))
    else $error("unaveraged sample was not stored");

  avg_len_a: assert property (
    (sample_valid_i && averaging_select > 3'h4 && s.avg_cnt < 6'h1F) |-> !group_done)
    else $error("averaging group shorter than 32");

  wrap_store_a: assert property (
    (group_done && s.full && wrap_on_full_enable && !new_req)
      |=> (s.full && s.write_index == $past(s.write_index) + 5'h01))
    else $error("wrap on full did not keep writing");

  hold_full_a: assert property (
    drop_s |=> $stable(s.write_index) && s.full)
    else $error("sample stored into a full buffer");

  lost_sat_a: assert property (
    (drop_s ##0 (s.lost_sample_count == osf_pkg::LOST_MAX)) |=> (s.lost_sample_count ==
     osf_pkg::LOST_MAX))
    else $error("lost count did not saturate");

  af_fire_a: assert property (
    (stored && !new_req && !s.full
     && (s.read_index - s.write_index - 5'h01) == {1'b0, full_threshold}) |=> s.almost_full)
    else $error("almost-full did not fire at the threshold");

  af_sticky_a: assert property (
    (s.almost_full && !(rd_req && s.reg_addr == osf_pkg::STATUS1_ADDR)) |=> s.almost_full)
    else $error("almost-full flag dropped without a status read");

  af_clear_a: assert property (
    (status_read_s ##0 !stored) |=> !s.almost_full)
    else $error("status read did not clear almost-full");

  status_bits_a: assert property (
    status_read_s |=> (s.rdata == {$past(s.almost_full), 7'h00}))
    else $error("status byte does not show the almost-full flag");

  empty_read_a: assert property (
    (port_rd && s.byte_idx == 3'h0 && empty) |=> (s.rdata == 8'h00 && $stable(s.read_index)))
    else $error("empty data port read moved the read index");

  drop_count_a: assert property (
    (dropped && !new_req && s.lost_sample_count != osf_pkg::LOST_MAX)
      |=> (s.lost_sample_count == $past(s.lost_sample_count) + 5'h01))
    else $error("lost count did not step on a dropped sample");

  count_bound_a: assert property (
    s.full |-> (s.write_index == s.read_index))
    else $error("full flag set while indices differ");
endmodule : optical_sample_fifo
`default_nettype wire

//--- rtl/osf_pkg.sv
package osf_pkg;
  localparam int DEPTH = 32;
  localparam int IDX_W = 5;
  localparam int CH_W = 18;
  localparam int ENTRY_W = 36;
  localparam int ACC_W = 23;
  localparam logic [7:0] STATUS1_ADDR = 8'h00;
  localparam logic [7:0] WRITE_INDEX_ADDR = 8'h04;
  localparam logic [7:0] LOST_COUNT_ADDR = 8'h05;
  localparam logic [7:0] READ_INDEX_ADDR = 8'h06;
  localparam logic [7:0] SAMPLE_PORT_ADDR = 8'h07;
  localparam logic [7:0] BUFFER_CFG_ADDR = 8'h08;
  localparam logic [7:0] TOP_ADDR = 8'hFF;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int AVG_LSB = 5;
  localparam int WRAP_BIT = 4;
  localparam int THR_LSB = 0;
  localparam int ALMOST_FULL_BIT = 7;
  localparam logic [4:0] LOST_MAX = 5'h1F;
  localparam logic [2:0] LAST_BYTE_ONE_CH = 3'h2;
  localparam logic [2:0] LAST_BYTE_TWO_CH = 3'h5;
  typedef enum logic [1:0] {LINK_SET_ADDR, LINK_WRITE, LINK_READ} link_op_t;
endpackage : osf_pkg

//--- rtl/osf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface osf_link_if;
  logic req_tgl;
  logic ack_tgl;
  osf_pkg::link_op_t op;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport link_end (output req_tgl, output op, output wdata, input ack_tgl, input rdata);
  modport core_end (input req_tgl, input op, input wdata, output ack_tgl, output rdata);
endinterface : osf_link_if
`default_nettype wire

//--- rtl/osf_link_port.sv
`timescale 1ns/1ps
`default_nettype none
module osf_link_port (
  input wire logic link_clk_i,
  input wire logic nrst_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_op_i,
  input wire logic [7:0] cmd_byte_i,
  output logic cmd_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_byte_o,
  osf_link_if.link_end xf
);
  typedef struct packed {
    logic [1:0] rst_pipe;
    logic [1:0] ack_pipe;
    logic busy;
    logic req_tgl;
    osf_pkg::link_op_t op;
    logic [7:0] wdata;
    logic rsp_valid;
    logic [7:0] rsp_byte;
  } link_state_t;

  link_state_t s;
  link_state_t next;
  logic done;

  // op and wdata stay frozen while busy, so the core may sample them after the toggle
  assign done = s.busy && (s.ack_pipe[1] == s.req_tgl);

  always_comb begin
    next = s;
    next.rst_pipe = {s.rst_pipe[0], nrst_i};
    next.ack_pipe = {s.ack_pipe[0], xf.ack_tgl};
    next.rsp_valid = 1'b0;
    if (done) begin
      next.busy = 1'b0;
      next.rsp_valid = (s.op == osf_pkg::LINK_READ);
      if (s.op == osf_pkg::LINK_READ) begin
        next.rsp_byte = xf.rdata;
      end
    end else if (cmd_valid_i && !s.busy) begin
      next.busy = 1'b1;
      next.req_tgl = !s.req_tgl;
      next.op = osf_pkg::link_op_t'(cmd_op_i);
      next.wdata = cmd_byte_i;
    end
    if (!s.rst_pipe[1]) begin
      next = '0;
      next.rst_pipe = {s.rst_pipe[0], nrst_i};
    end
  end

  always_ff @(posedge link_clk_i) begin
    s <= next;
  end

  assign cmd_ready_o = !s.busy && s.rst_pipe[1];
  assign rsp_valid_o = s.rsp_valid;
  assign rsp_byte_o = s.rsp_byte;
  assign xf.req_tgl = s.req_tgl;
  assign xf.op = s.op;
  assign xf.wdata = s.wdata;

  link_hold_a: assert property (@(posedge link_clk_i) disable iff (!s.rst_pipe[1])
    (s.busy && !done) |=> (s.busy && $stable(s.wdata) && $stable(s.op)))
    else $error("link request changed before it was answered");
endmodule : osf_link_port
`default_nettype wire

//--- verification/osf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module osf_host_model (
  input wire logic link_clk_i,
  input wire logic cmd_ready_i,
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_byte_i,
  output logic cmd_valid_o,
  output logic [1:0] cmd_op_o,
  output logic [7:0] cmd_byte_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = 2'h0;
    cmd_byte_o = 8'h00;
  end

  // ready is settled at the falling edge, so the next rising edge takes the byte
  task automatic xfer(input logic [1:0] op, input logic [7:0] b, output logic [7:0] d,
    output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(negedge link_clk_i);
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_byte_o = b;
    for (n = 0; n < 16 && !ok; n++) begin
      if (cmd_ready_i === 1'b1) ok = 1'b1;
      else @(negedge link_clk_i);
    end
    if (ok) @(negedge link_clk_i);
    cmd_valid_o = 1'b0;
    // a released byte shows its inverse so stale data never looks valid
    cmd_byte_o = ~b;
    if (ok && op == 2'h2) begin
      ok = 1'b0;
      for (n = 0; n < 8 && !ok; n++) begin
        if (rsp_valid_i === 1'b1) begin
          ok = 1'b1;
          d = rsp_byte_i;
        end else @(negedge link_clk_i);
      end
    end
  endtask : xfer

  // n read transactions in a row, address set once
  task automatic burst_rd(input logic [7:0] a, input int n, output logic [7:0] q [6],
    output bit ok);
    logic [7:0] d;
    xfer(2'h0, a, d, ok);
    for (int k = 0; k < n && ok; k++) xfer(2'h2, 8'h00, q[k], ok);
  endtask : burst_rd

  // host only rewrites indices, lost count and config
  task automatic burst_wr(input logic [7:0] a, input int n, input logic [7:0] w [6],
    output bit ok);
    logic [7:0] d;
    xfer(2'h0, a, d, ok);
    for (int k = 0; k < n && ok; k++) xfer(2'h1, w[k], d, ok);
  endtask : burst_wr
endmodule : osf_host_model
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic [1:0] res; logic one; logic [17:0] red; logic [17:0] ir;
    logic [17:0] ered; logic [17:0] eir;} row_t;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic sample_valid = 1'b0;
  logic [17:0] red = 18'h00000;
  logic [17:0] ir = 18'h00000;
  logic [1:0] res = 2'h3;
  logic single = 1'b0;
  logic cmd_valid, cmd_ready, rsp_valid, af;
  logic [1:0] cmd_op;
  logic [7:0] cmd_byte, rsp_byte;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] q [6];
  logic [7:0] w [6];
  // expected words are the raw results with their msb moved up to bit 17
  row_t rows [4] = '{'{2'h3, 1'b0, 18'h2C3D5, 18'h1A2B3, 18'h2C3D5, 18'h1A2B3},
    '{2'h0, 1'b1, 18'h05A5B, 18'h00000, 18'h2D2D8, 18'h00000},
    '{2'h1, 1'b0, 18'h0F0F1, 18'h08001, 18'h3C3C4, 18'h20004},
    '{2'h2, 1'b1, 18'h1FFFF, 18'h00000, 18'h3FFFE, 18'h00000}};

  initial forever #5 sys_clk = ~sys_clk;
  initial begin
    #37;
    forever #80 link_clk = ~link_clk;
  end

  optical_sample_fifo uut (.sys_clk_i(sys_clk), .nrst_i(nrst), .link_clk_i(link_clk),
    .link_cmd_valid_i(cmd_valid), .link_cmd_op_i(cmd_op), .link_cmd_byte_i(cmd_byte),
    .link_cmd_ready_o(cmd_ready), .link_rsp_valid_o(rsp_valid), .link_rsp_byte_o(rsp_byte),
    .sample_valid_i(sample_valid), .sample_red_i(red), .sample_ir_i(ir),
    .adc_resolution_i(res), .single_channel_mode_i(single), .almost_full_o(af));

  osf_host_model host (.link_clk_i(link_clk), .cmd_ready_i(cmd_ready),
    .rsp_valid_i(rsp_valid), .rsp_byte_i(rsp_byte), .cmd_valid_o(cmd_valid),
    .cmd_op_o(cmd_op), .cmd_byte_o(cmd_byte));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic stuck(input bit ok);
    if (!ok) begin
      n_mismatch++;
      $display("link handshake timed out");
      give_verdict();
    end
  endtask : stuck

  task automatic rd(input logic [7:0] a, input int n);
    bit ok;
    host.burst_rd(a, n, q, ok);
    stuck(ok);
  endtask : rd

  task automatic wr(input logic [7:0] a, input int n);
    bit ok;
    host.burst_wr(a, n, w, ok);
    stuck(ok);
  endtask : wr

  task automatic setcfg(input logic [7:0] c);
    w[0] = c;
    wr(8'h08, 1);
  endtask : setcfg

  // zero write index, lost count, read index; reading status drops almost-full
  task automatic clr;
    w = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    wr(8'h04, 3);
    rd(8'h00, 1);
  endtask : clr

  task automatic push(input logic [17:0] r, input logic [17:0] i);
    @(negedge sys_clk);
    sample_valid = 1'b1;
    red = r;
    ir = i;
    @(negedge sys_clk);
    sample_valid = 1'b0;
  endtask : push

  task automatic afchk(input logic e);
    repeat (3) @(negedge sys_clk);
    chk1("almost full", e, af);
  endtask : afchk

  task automatic do_reset;
    nrst = 1'b0;
    repeat (4) @(negedge link_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
  endtask : do_reset

  function automatic logic [7:0] ebyte(input logic [17:0] v, input int k);
    return k == 0 ? {6'h00, v[17:16]} : (k == 1 ? v[15:8] : v[7:0]);
  endfunction : ebyte

  initial begin
    int i, k, j, n, nb;
    logic [17:0] rv, iv;
    do_reset();
    rd(8'h04, 3);
    for (k = 0; k < 3; k++) chk8("index at reset", 8'h00, q[k]);
    rd(8'h08, 1);
    chk8("config at reset", 8'h00, q[0]);
    setcfg(8'h0A);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      res = rows[i].res;
      single = rows[i].one;
      clr();
      push(rows[i].red, rows[i].ir);
      nb = single ? 3 : 6;
      rd(8'h04, 1);
      chk8("unread before fetch", 8'h01, q[0]);
      rd(8'h07, nb);
      rv = rows[i].ered;
      iv = rows[i].eir;
      for (k = 0; k < nb; k++) chk8("sample byte", ebyte(k < 3 ? rv : iv, k % 3), q[k]);
      rd(8'h04, 3);
      chk8("write index", 8'h01, q[0]);
      chk8("read index", 8'h01, q[2]);
    end
    $display("test sample rows done");
    w[0] = 8'h00;
    wr(8'h06, 1);
    rd(8'h07, 3);
    for (k = 0; k < 3; k++) chk8("reread byte", ebyte(rv, k), q[k]);
    rd(8'h05, 4);
    chk8("lost count", 8'h00, q[0]);
    chk8("read index", 8'h01, q[1]);
    chk8("empty port", 8'h00, q[2]);
    chk8("port again", 8'h00, q[3]);
    $display("test address walk done");
    res = 2'h3;
    single = 1'b1;
    for (i = 0; i < 8; i++) begin
      n = i > 4 ? 32 : (1 << i);
      setcfg(8'(i << 5));
      clr();
      for (j = 0; j < n - 1; j++) push(18'h00100 + 18'(2 * (j % 2)), 18'h00000);
      rd(8'h04, 1);
      chk8("partial group", 8'h00, q[0]);
      push(18'h00100 + 18'(2 * ((n - 1) % 2)), 18'h00000);
      rd(8'h04, 1);
      chk8("group stored", 8'h01, q[0]);
      rd(8'h07, 3);
      chk8("average", n == 1 ? 8'h00 : 8'h01, q[2]);
    end
    $display("test averaging done");
    setcfg(8'h00);
    clr();
    for (k = 0; k < 31; k++) push(18'(k), 18'(k));
    afchk(1'b0);
    push(18'h0001F, 18'h0001F);
    afchk(1'b1);
    push(18'h00000, 18'h00000);
    push(18'h00000, 18'h00000);
    rd(8'h04, 2);
    chk8("write index full", 8'h00, q[0]);
    chk8("lost count", 8'h02, q[1]);
    for (k = 0; k < 33; k++) push(18'h00000, 18'h00000);
    rd(8'h05, 1);
    chk8("lost saturated", 8'h1F, q[0]);
    rd(8'hFF, 2);
    chk8("past top", 8'h00, q[1]);
    rd(8'h00, 1);
    chk8("status", 8'h80, q[0]);
    rd(8'h00, 1);
    chk8("status cleared", 8'h00, q[0]);
    afchk(1'b0);
    rd(8'h07, 1);
    rd(8'h05, 2);
    chk8("lost after pop", 8'h00, q[0]);
    chk8("read index pop", 8'h01, q[1]);
    push(18'h00005, 18'h00005);
    rd(8'h04, 1);
    chk8("store after pop", 8'h01, q[0]);
    $display("test full hold done");
    setcfg(8'h1F);
    clr();
    for (k = 0; k < 16; k++) push(18'(k), 18'h00000);
    afchk(1'b0);
    push(18'h00010, 18'h00000);
    afchk(1'b1);
    for (k = 17; k < 33; k++) push(18'(k), 18'h00000);
    rd(8'h04, 3);
    chk8("write index wrap", 8'h01, q[0]);
    chk8("lost on wrap", 8'h00, q[1]);
    rd(8'h07, 3);
    chk8("oldest kept", 8'h01, q[2]);
    $display("test wrap done");
    do_reset();
    rd(8'h04, 3);
    for (k = 0; k < 3; k++) chk8("index after reset", 8'h00, q[k]);
    rd(8'h08, 1);
    chk8("config after reset", 8'h00, q[0]);
    chk1("almost full after reset", 1'b0, af);
    $display("test second reset done");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
